// [design/core_interrupt_logic.sv]
// Purpose: interrupt collection, gating and vectoring for the processor core
// Assumes: core decodes return_from_handler and gives the stack/shadow stores
// Notes:   registers are plain ports; software access arrives as write strobes
`timescale 1ns/1ps
`default_nettype none
module core_interrupt_logic (
    input  wire logic        CLK_SYS_IN,
    input  wire logic        RSTN_IN,
    input  wire logic        EXT_PIN_IN,
    input  wire logic [71:0] SRC_EVENT_IN,
    input  wire logic [71:0] FLAG_CLEAR_IN,
    input  wire logic [8:0]  ENABLE_WR_IN,
    input  wire logic [7:0]  ENABLE_WDATA_IN,
    input  wire logic        CTRL_WR_IN,
    input  wire logic        GLOBAL_EN_WDATA_IN,
    input  wire logic        GROUP_EN_WDATA_IN,
    input  wire logic        EDGE_WDATA_IN,
    input  wire logic        RETURN_FROM_HANDLER_IN,
    input  wire logic        SLEEPING_IN,
    input  wire logic [14:0] PC_IN,
    input  wire logic [47:0] CONTEXT_IN,
    output logic [71:0]      SOURCE_FLAG_REGS_OUT,
    output logic [71:0]      SOURCE_ENABLE_REGS_OUT,
    output logic             GLOBAL_IRQ_ENABLE_OUT,
    output logic             PERIPH_GROUP_ENABLE_OUT,
    output logic             EXT_EDGE_SELECT_OUT,
    output logic [1:0]       QUARTER_OUT,
    output logic             FLUSH_OUT,
    output logic             PUSH_PC_OUT,
    output logic [14:0]      PUSH_ADDR_OUT,
    output logic             LOAD_PC_OUT,
    output logic [14:0]      PC_LOAD_OUT,
    output logic             SHADOW_SAVE_OUT,
    output logic [47:0]      SHADOW_CTX_OUT,
    output logic             POP_PC_OUT,
    output logic             SHADOW_RESTORE_OUT,
    output logic             WAKE_OUT
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [1:0]  quarter;
    logic        global_irq_enable;
    logic        periph_group_enable;
    logic        ext_edge_select;
    logic [7:0]  source_flag_regs   [irq_pkg::NUM_REGS];
    logic [7:0]  source_enable_regs [irq_pkg::NUM_REGS];
    logic [2:0]  pin_sync;
    logic [3:0]  pin_fill;
    logic        pin_prev;
    logic        take;
    logic        take_d;
    logic        wake_hold;
    logic [47:0] shadow_ctx;
    logic [8:0]  reg_hit;

    wire first_quarter_phase  = (quarter == irq_pkg::FIRST_QUARTER);
    wire fourth_quarter_phase = (quarter == irq_pkg::LAST_QUARTER);

    // synchronised pin: change counts once stages two and three agree
    wire pin_stable = (pin_sync[2] == pin_sync[1]);
    wire pin_level  = pin_sync[1];
    // edges count only once the chain holds real pin samples, so an
    // idle-high pin cannot fake a rising edge just after reset
    wire pin_armed  = pin_fill[3];
    wire pin_rise   = pin_armed && pin_stable && pin_level && !pin_prev;
    wire pin_fall   = pin_armed && pin_stable && !pin_level && pin_prev;
    wire pin_event  = ext_edge_select ? pin_rise : pin_fall;

    // ----------------------------------------
    // quarter phase divider
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            quarter <= irq_pkg::FIRST_QUARTER;
        end else begin
            quarter <= quarter + 2'h1;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            pin_sync <= 3'h0;
            pin_fill <= 4'h0;
            pin_prev <= 1'b0;
        end else begin
            pin_sync <= {pin_sync[1:0], EXT_PIN_IN};
            pin_fill <= {pin_fill[2:0], 1'b1};
            if (pin_stable) begin
                pin_prev <= pin_level;
            end
        end
    end

    // ----------------------------------------
    // flag and enable registers
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < irq_pkg::NUM_REGS; g++) begin : gen_regs
            logic [7:0] ev;
            logic [7:0] pending;
            // the pin edge is OR-ed into its flag; set wins over clear
            assign ev = SRC_EVENT_IN[g*8 +: 8]
                      | ((g == 0) ? (8'h01 & {8{pin_event}}) : 8'h00);
            assign pending = source_flag_regs[g] & source_enable_regs[g];
            // register 0 needs no group enable others do
            assign reg_hit[g] = (|pending) && ((g == 0) || periph_group_enable);
            always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
                if (!RSTN_IN) begin
                    source_flag_regs[g]   <= irq_pkg::FLAG_RESET;
                    source_enable_regs[g] <= irq_pkg::ENABLE_RESET;
                end else begin
                    // flags ignore every enable and keep recording
                    source_flag_regs[g] <= (source_flag_regs[g]
                                           & ~FLAG_CLEAR_IN[g*8 +: 8]) | ev;
                    if (ENABLE_WR_IN[g]) begin
                        source_enable_regs[g] <= ENABLE_WDATA_IN;
                    end
                end
            end
            assign SOURCE_FLAG_REGS_OUT[g*8 +: 8]   = source_flag_regs[g];
            assign SOURCE_ENABLE_REGS_OUT[g*8 +: 8] = source_enable_regs[g];
        end
    endgenerate

    wire any_pending = |reg_hit;

    // sampled only in the first quarter, so a pin flag set during the
    // fourth quarter is seen by the very next sample
    wire sample_take = first_quarter_phase && global_irq_enable && any_pending
                       && !SLEEPING_IN && !wake_hold;

    // ----------------------------------------
    // global control and vectoring
    // ----------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            global_irq_enable   <= irq_pkg::GLOBAL_EN_RESET;
            periph_group_enable <= irq_pkg::GROUP_EN_RESET;
            ext_edge_select     <= irq_pkg::EDGE_RESET;
        end else begin
            if (sample_take) begin
                global_irq_enable <= 1'b0;
            end else if (RETURN_FROM_HANDLER_IN) begin
                global_irq_enable <= 1'b1;
            end else if (CTRL_WR_IN) begin
                global_irq_enable <= GLOBAL_EN_WDATA_IN;
            end
            if (CTRL_WR_IN) begin
                periph_group_enable <= GROUP_EN_WDATA_IN;
                ext_edge_select     <= EDGE_WDATA_IN;
            end
        end
    end

    // take: flush/push/shadow one clock after the sample cycle, jump a clock later,
    // giving the core the rest of the cycle to reach the vector
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            take       <= 1'b0;
            take_d     <= 1'b0;
            shadow_ctx <= 48'h0;
        end else begin
            take   <= sample_take;
            take_d <= take;
            if (sample_take) begin
                shadow_ctx <= CONTEXT_IN;
            end
        end
    end

    // after a wake no vector is sampled until the instruction cycle in progress ends at its fourth quarter
    always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
            wake_hold <= 1'b0;
        end else if (SLEEPING_IN && any_pending) begin
            wake_hold <= 1'b1;
        end else if (fourth_quarter_phase && !SLEEPING_IN) begin
            wake_hold <= 1'b0;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign GLOBAL_IRQ_ENABLE_OUT   = global_irq_enable;
    assign PERIPH_GROUP_ENABLE_OUT = periph_group_enable;
    assign EXT_EDGE_SELECT_OUT     = ext_edge_select;
    assign QUARTER_OUT             = quarter;
    assign FLUSH_OUT               = take;
    assign PUSH_PC_OUT             = take;
    assign PUSH_ADDR_OUT           = PC_IN;
    assign SHADOW_SAVE_OUT         = take;
    assign SHADOW_CTX_OUT          = shadow_ctx;
    assign LOAD_PC_OUT             = take_d;
    assign PC_LOAD_OUT             = irq_pkg::IRQ_VECTOR;
    assign POP_PC_OUT              = RETURN_FROM_HANDLER_IN;
    assign SHADOW_RESTORE_OUT      = RETURN_FROM_HANDLER_IN;
    // wake needs only source and group enables, not the global one
    assign WAKE_OUT                = SLEEPING_IN && any_pending;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_take_needs_global: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        take |-> $past(global_irq_enable))
        else $error("vector taken while globally disabled");
    a_take_clears_global: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        take |-> !global_irq_enable)
        else $error("global enable not cleared on take");
    a_vector_load: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        take |=> LOAD_PC_OUT && PC_LOAD_OUT == irq_pkg::IRQ_VECTOR)
        else $error("vector not loaded after take");
    a_take_on_q1: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        take |-> $past(quarter) == 2'h0)
        else $error("take outside first quarter");
    a_return_sets_global: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        RETURN_FROM_HANDLER_IN && !sample_take |=> global_irq_enable)
        else $error("return did not set global enable");
    a_flag_sets: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        SRC_EVENT_IN[8] |=> source_flag_regs[1][0])
        else $error("flag not set on event");
    a_pending_taken: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        global_irq_enable && any_pending && !SLEEPING_IN && !wake_hold
            && first_quarter_phase |=> take)
        else $error("pending request not taken");
    a_group_gate: assert property (@(posedge CLK_SYS_IN) disable iff (!RSTN_IN)
        take |-> $past(reg_hit[0] || periph_group_enable))
        else $error("peripheral vector without group enable");
endmodule
`default_nettype wire

// [pkg/irq_pkg.sv]
// Purpose: constants shared by the core interrupt logic
// Assumes: 10 MHz system clock, four clocks per instruction cycle
// Notes:   flag and enable registers are 8 bits, nine of each
`default_nettype none
package irq_pkg;
    // ----------------------------------------
    // geometry
    // ----------------------------------------
    localparam int unsigned NUM_REGS      = 9;
    localparam int unsigned REG_W         = 8;
    localparam int unsigned PC_W          = 15;
    localparam int unsigned CTX_W         = 48;
    // ----------------------------------------
    // vector and reset values
    // ----------------------------------------
    localparam logic [14:0] IRQ_VECTOR    = 15'h0004;
    localparam logic        GLOBAL_EN_RESET = 1'b0;
    localparam logic        GROUP_EN_RESET  = 1'b0;
    localparam logic        EDGE_RESET    = 1'b1;
    localparam logic [7:0]  ENABLE_RESET  = 8'h00;
    localparam logic [7:0]  FLAG_RESET    = 8'h00;
    // ----------------------------------------
    // timing: quarter phases per instruction cycle
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned INSTR_CYCLE_NS = 400;
    localparam int unsigned QUARTERS      = INSTR_CYCLE_NS / CLK_PERIOD_NS;
    localparam logic [1:0]  FIRST_QUARTER = 2'h0;
    localparam logic [1:0]  LAST_QUARTER  = 2'(QUARTERS - 1);
    // flag bit of the external pin within flag register 0
    localparam int unsigned EXT_PIN_BIT   = 0;
endpackage
`default_nettype wire

// [sim/core_interrupt_logic_tb.sv]
// Purpose: self-checking bench for the core interrupt logic
// Assumes: inputs change at the falling clock edge
// Notes:   every take is checked by the watcher process
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", nm, ex, got); end end
module core_interrupt_logic_tb;
    logic [71:0] ev, fclr, fl, en, xf, xe, v;
    logic [8:0]  en_wr;
    logic [7:0]  en_wd;
    logic [1:0]  qtr;
    logic [14:0] pc, pa, pl;
    logic [47:0] ctx, shd, cq;
    logic [31:0] seed;
    logic        clk, rstn, pin, cw, gw, pw, ew, ret, slp, fl_d;
    logic        glob, grp, esel, flush, push, load, pop, rst, wake, save;
    int          bad_count, n_compared, takes, t0, i, j;
    always #50 clk = ~clk;
    core_interrupt_logic dut_u (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .EXT_PIN_IN(pin),
        .SRC_EVENT_IN(ev), .FLAG_CLEAR_IN(fclr), .ENABLE_WR_IN(en_wr), .ENABLE_WDATA_IN(en_wd),
        .CTRL_WR_IN(cw), .GLOBAL_EN_WDATA_IN(gw), .GROUP_EN_WDATA_IN(pw), .EDGE_WDATA_IN(ew),
        .RETURN_FROM_HANDLER_IN(ret), .SLEEPING_IN(slp), .PC_IN(pc), .CONTEXT_IN(ctx),
        .SOURCE_FLAG_REGS_OUT(fl), .SOURCE_ENABLE_REGS_OUT(en), .GLOBAL_IRQ_ENABLE_OUT(glob),
        .PERIPH_GROUP_ENABLE_OUT(grp), .EXT_EDGE_SELECT_OUT(esel), .QUARTER_OUT(qtr),
        .FLUSH_OUT(flush), .PUSH_PC_OUT(push), .PUSH_ADDR_OUT(pa), .LOAD_PC_OUT(load),
        .PC_LOAD_OUT(pl), .SHADOW_SAVE_OUT(save), .SHADOW_CTX_OUT(shd), .POP_PC_OUT(pop),
        .SHADOW_RESTORE_OUT(rst), .WAKE_OUT(wake));
    core_model core_u (.clk_in(clk), .rstn_in(rstn), .quarter_in(qtr), .push_in(push),
        .push_addr_in(pa), .load_in(load), .pc_load_in(pl), .pop_in(pop), .pc_out(pc),
        .ctx_out(ctx));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    function automatic int exp_take(input logic [71:0] f, e, input logic p);
        return int'((|(f[7:0] & e[7:0])) || (p && (|(f[71:8] & e[71:8]))));
    endfunction
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic stop_test;
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic do_reset;
        rstn = 1'b0;
        tick(12);
        rstn = 1'b1;
        `CHK("reset", {144'h0, 3'h1}, {fl, en, glob, grp, esel})
    endtask
    task automatic ctl(input logic g, p, e);
        {cw, gw, pw, ew} = {1'b1, g, p, e};
        tick(1);
        cw = 1'b0;
    endtask
    task automatic pulse(input logic [71:0] b, input logic clr);
        if (clr)
            fclr = b;
        else
            ev = b;
        tick(1);
        {fclr, ev} = '0;
    endtask
    task automatic wr_en(input int g, input logic [7:0] d);
        {en_wr, en_wd} = {9'h001 << g, d};
        tick(1);
        en_wr = '0;
    endtask
    task automatic takes_in(input int n, k);
        t0 = takes;
        tick(n);
        `CHK("takes", k, takes - t0)
    endtask
    task automatic hret;
        ret = 1'b1;
        #1 `CHK("pop restore", 2'h3, {pop, rst})
        tick(1);
        ret = 1'b0;
        `CHK("global set", 1'b1, glob)
    endtask
    // watcher: every vector entry must carry the whole sequence
    always @(posedge clk) if (rstn) begin
        fl_d <= flush;
        `CHK("load", fl_d, load)
        if (qtr == 2'h0)
            cq <= ctx;
        if (flush) begin
            takes++;
            `CHK("take phase", 2'h1, qtr)
            `CHK("entry", {2'h3, 1'b0, pc}, {push, save, glob, pa})
            `CHK("shadow", cq, shd)
        end
        if (load)
            `CHK("vector", 15'h0004, pl)
    end
    initial begin
        #2000000;
        bad_count++;
        stop_test();
    end
    initial begin
        {clk, rstn, pin, cw, gw, pw, ew, ret, slp, fl_d} = 10'h008;
        {ev, fclr, en_wr, en_wd, bad_count, n_compared, takes} = '0;
        seed = 32'hFF2D;
        do_reset();
        {ev, fclr} = {72'hFF_FFFF_FFFF_FFFF_FFFF, 72'hFF_FFFF_FFFF_FFFF_FFFF};
        tick(1);
        `CHK("set beats clear", 72'hFF_FFFF_FFFF_FFFF_FFFF, fl)
        pulse(fl, 1'b0);
        pulse('1, 1'b1);
        xf = '0;
        for (i = 0; i < 9; i++) begin
            seed = xs(seed);
            v = {seed[7:0], xs(seed), xs(xs(seed))};
            pulse(v, 1'b0);
            xf = xf | v;
            `CHK("flags", xf, fl)
            wr_en(i, seed[15:8]);
            xe[i*8+:8] = seed[15:8];
        end
        `CHK("enables", xe, en)
        takes_in(8, 0);
        ctl(1'b1, seed[20], 1'b1);
        takes_in(12, exp_take(xf, xe, seed[20]));
        do_reset();
        wr_en(3, 8'h20);
        pulse(72'h1 << 29, 1'b0);
        ctl(1'b1, 1'b0, 1'b1);
        takes_in(12, 0);
        ctl(1'b1, 1'b1, 1'b1);
        takes_in(8, 1);
        pulse(72'h1 << 29, 1'b1);
        `CHK("flag cleared", 1'b0, fl[29])
        pulse(72'h1 << 29, 1'b0);
        `CHK("flag in handler", 1'b1, fl[29])
        takes_in(12, 0);
        hret();
        takes_in(8, 1);
        pulse(72'h1 << 29, 1'b1); // handler polls then clears
        hret();
        takes_in(12, 0);
        for (j = 0; j < 2; j++) begin
            ctl(1'b0, 1'b0, j[0]);
            pin = j[0];
            tick(6);
            pulse(72'h1, 1'b1);
            pin = ~j[0];
            tick(6);
            `CHK("wrong edge", 1'b0, fl[0])
            pin = j[0];
            tick(6);
            `CHK("right edge", 1'b1, fl[0])
        end
        pulse(72'h1, 1'b1);
        wr_en(0, 8'h01);
        ctl(1'b1, 1'b0, 1'b1);
        pin = 1'b0;
        tick(6);
        pin = 1'b1;
        t0 = takes;
        for (i = 0; i < 24 && takes == t0; i++)
            tick(1);
        `CHK("latency", 1'b1, i <= 20)
        slp = 1'b1;
        tick(1);
        `CHK("wake", 1'b1, wake)
        ctl(1'b1, 1'b0, 1'b1);
        takes_in(8, 0);
        slp = 1'b0;
        takes_in(12, 1);
        stop_test();
    end
endmodule
`default_nettype wire

// [sim/core_model.sv]
// Purpose: behavioural processor core facing the interrupt logic
// Assumes: one instruction per four clocks, pc steps at the last quarter
// Notes:   context follows the pc so a stale shadow copy shows up
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input  wire logic        clk_in,
    input  wire logic        rstn_in,
    input  wire logic [1:0]  quarter_in,
    input  wire logic        push_in,
    input  wire logic [14:0] push_addr_in,
    input  wire logic        load_in,
    input  wire logic [14:0] pc_load_in,
    input  wire logic        pop_in,
    output logic      [14:0] pc_out,
    output logic      [47:0] ctx_out
);
    logic [14:0] stack;
    assign ctx_out = {3'h5, pc_out, ~pc_out, pc_out};
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pc_out <= 15'h0100;
            stack  <= 15'h0000;
        end else begin
            if (push_in)
                stack <= push_addr_in;
            if (load_in)
                pc_out <= pc_load_in;
            else if (pop_in)
                pc_out <= stack;
            else if (quarter_in == 2'h3)
                pc_out <= pc_out + 15'h0001;
        end
    end
endmodule
`default_nettype wire
